// File: design/rci_pkg.sv
// Constants, register map and mode type for the reset cause and isolation block
package rci_pkg;

    // ============================================================
    // Widths
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned GPIO_PINS = 41;
    localparam int unsigned CAUSE_W   = 4;
    localparam int unsigned IRQ_W     = 3;

    // ============================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CAUSE    = 16'h1f92;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 16'h1f93;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'h1f94;
    localparam logic [ADDR_W-1:0] ADDR_MODE     = 16'h1f95;

    // ============================================================
    // Field positions
    localparam int unsigned CAUSE_EXT   = 0;
    localparam int unsigned CAUSE_SW    = 1;
    localparam int unsigned CAUSE_WDT   = 2;
    localparam int unsigned CAUSE_CFD   = 3;
    localparam int unsigned IRQ_CAUSE   = 0;
    localparam int unsigned IRQ_ISO_ON  = 1;
    localparam int unsigned IRQ_ISO_OFF = 2;
    localparam int unsigned MODE_B_ISO  = 0;
    localparam int unsigned MODE_B_RST  = 1;

    // Position of the shared port 2 bit 6 pin inside the pin vector
    localparam int unsigned SHARED_PIN_IDX = 22;

    // ============================================================
    // Reset values and pad levels
    localparam logic [CAUSE_W-1:0]   CAUSE_RST     = 4'h0;
    localparam logic [IRQ_W-1:0]     IRQ_RST       = 3'h0;
    localparam logic [DATA_W-1:0]    BYTE_ZERO     = 8'h00;
    localparam logic [GPIO_PINS-1:0] ISO_PULL_DEF  = 41'h0;
    localparam logic                 PAD_PULL_ON   = 1'b1;
    localparam logic                 PAD_PULL_OFF  = 1'b0;
    localparam logic                 PAD_LEVEL_LOW = 1'b0;
    localparam logic                 PAD_DRV_OFF   = 1'b0;

    // ============================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_RESET,
        MODE_ISOLATE
    } rci_mode_t;

endpackage : rci_pkg

// File: design/rci_ctl_if.sv
// Control signals between the sequencer, the entry detector and the pad control
`timescale 1ns/1ps
`default_nettype none
interface rci_ctl_if;
    logic pads_reset;   // Pads take the reset state
    logic pads_iso;     // Pads take the isolation state
    logic entry_req;    // Isolation entry seen at reset release

    modport top (output pads_reset, output pads_iso, input entry_req);
    modport det (output entry_req);
    modport pad (input pads_reset, input pads_iso);
endinterface : rci_ctl_if
`default_nettype wire

// File: design/rci_iso_detect.sv
// Detects the isolation entry condition at the rising edge of the reset pin
`timescale 1ns/1ps
`default_nettype none
module rci_iso_detect
    import rci_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic ext_reset_n_i,
    input  wire logic mode_pin_i,
    rci_ctl_if.det    ctl
);

    // ============================================================
    // History of reset pin and mode pin
    logic ext_prev_q;
    logic pin_prev_q;

    // Power-on counts as reset held low and mode pin low, so a pin high at the power-on release is not seen
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ext_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_reset_n_i;
            pin_prev_q <= mode_pin_i;
        end
    end

    // Pin must be high before and at the release edge
    assign ctl.entry_req = ext_reset_n_i & ~ext_prev_q & mode_pin_i & pin_prev_q;

endmodule : rci_iso_detect
`default_nettype wire

// File: design/rci_pad_ctrl.sv
// Per-pin drive and weak pull control for reset, isolation and run states
`timescale 1ns/1ps
`default_nettype none
module rci_pad_ctrl
    import rci_pkg::*;
#(
    parameter int unsigned            PINS        = GPIO_PINS,
    parameter logic [GPIO_PINS-1:0]   ISO_PULL_UP = ISO_PULL_DEF
)(
    input  wire logic            mclk_i,
    input  wire logic            sys_rst_i,
    input  wire logic [PINS-1:0] gpio_out_i,
    input  wire logic [PINS-1:0] gpio_oe_i,
    rci_ctl_if.pad               ctl,
    output wire logic [PINS-1:0] pin_out_o,
    output wire logic [PINS-1:0] pin_oe_o,
    output wire logic [PINS-1:0] pin_pull_en_o,
    output wire logic [PINS-1:0] pin_pull_up_o
);

    // ============================================================
    // One registered pad slice per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pad
        logic out_q;
        logic oe_q;
        logic pull_en_q;
        logic pull_up_q;

        // Reset state is weak low, isolation is weak pull, run follows core
        always_ff @(posedge mclk_i) begin
            if (sys_rst_i || ctl.pads_reset) begin
                out_q     <= PAD_LEVEL_LOW;
                oe_q      <= PAD_DRV_OFF;
                pull_en_q <= PAD_PULL_ON;
                pull_up_q <= PAD_LEVEL_LOW;
            end else if (ctl.pads_iso) begin
                out_q     <= PAD_LEVEL_LOW;
                oe_q      <= PAD_DRV_OFF;
                pull_en_q <= PAD_PULL_ON;
                pull_up_q <= ISO_PULL_UP[i];
            end else begin
                out_q     <= gpio_out_i[i];
                oe_q      <= gpio_oe_i[i];
                pull_en_q <= PAD_PULL_OFF;
                pull_up_q <= PAD_LEVEL_LOW;
            end
        end

        assign pin_out_o[i]     = out_q;
        assign pin_oe_o[i]      = oe_q;
        assign pin_pull_en_o[i] = pull_en_q;
        assign pin_pull_up_o[i] = pull_up_q;
    end

endmodule : rci_pad_ctrl
`default_nettype wire

// File: design/rci_reset_seq.sv
// Reset cause log, isolation mode sequencer and register port
//
// What this block does
// - Keep a byte recording which sources caused a reset since the last cause read.
// - Several sources active together set every matching flag.
// - Reading the cause byte returns it, then clears all flags but those of sources active in the read cycle.
// - Bit 3 flags a reset from clock failure detection.
// - Mode pin held high across reset pin release enters isolation.
// - The mode entry pin is shared with port 2 bit 6.
// - In isolation all pins are weakly pulled, active drive released.
// - Reset pin low during isolation leaves it and enters reset.
// - During reset all 41 general pins sit at weak low.
`timescale 1ns/1ps
`default_nettype none
module rci_reset_seq
    import rci_pkg::*;
#(
    parameter int unsigned          PINS        = GPIO_PINS,
    parameter int unsigned          SHARED_IDX  = SHARED_PIN_IDX,
    parameter logic [GPIO_PINS-1:0] ISO_PULL_UP = ISO_PULL_DEF
)(
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              ext_reset_n_i,
    input  wire logic              clock_fail_i,
    input  wire logic              watchdog_i,
    input  wire logic              sw_reset_i,
    input  wire logic              bad_mode_key_i,
    input  wire logic [PINS-1:0]   gpio_in_i,
    input  wire logic [PINS-1:0]   gpio_out_i,
    input  wire logic [PINS-1:0]   gpio_oe_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   irq_o,
    output logic                   reset_state_o,
    output logic                   isolation_o,
    output wire logic [PINS-1:0]   pin_out_o,
    output wire logic [PINS-1:0]   pin_oe_o,
    output wire logic [PINS-1:0]   pin_pull_en_o,
    output wire logic [PINS-1:0]   pin_pull_up_o
);

    // ============================================================
    // Declarations
    rci_ctl_if ctl ();

    rci_mode_t          mode_q;
    rci_mode_t          mode_d;
    logic [CAUSE_W-1:0] cause_q;
    logic [CAUSE_W-1:0] cause_d;
    logic [CAUSE_W-1:0] src_vec;
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_stat_d;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic [IRQ_W-1:0]   irq_evt;
    logic               chip_rst;
    logic               rd_cause;
    logic               wr_stat;
    logic               wr_mask;
    logic               mode_pin;

    // ============================================================
    // Reset sources
    // Gather all active reset sources into their flag positions
    always_comb begin
        src_vec            = CAUSE_RST;
        src_vec[CAUSE_EXT] = ~ext_reset_n_i;
        src_vec[CAUSE_SW]  = sw_reset_i | bad_mode_key_i;
        src_vec[CAUSE_WDT] = watchdog_i;
        src_vec[CAUSE_CFD] = clock_fail_i;
    end

    // Any active source holds the controller in reset
    assign chip_rst = |src_vec;

    // Mode entry shares the port 2 bit 6 pad input
    assign mode_pin = gpio_in_i[SHARED_IDX];

    // Register strobes
    assign rd_cause = rd_i && (addr_i == ADDR_CAUSE);
    assign wr_stat  = wr_i && (addr_i == ADDR_IRQ_STAT);
    assign wr_mask  = wr_i && (addr_i == ADDR_IRQ_MASK);

    // ============================================================
    // Cause log
    // Read clears the byte; a source active in the same cycle still sets
    always_comb begin
        cause_d = (rd_cause ? CAUSE_RST : cause_q) | src_vec;
    end

    // Cause flags survive the controller reset; only power-on or a cause read clears them
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cause_q <= CAUSE_RST;
        end else begin
            cause_q <= cause_d;
        end
    end

    // ============================================================
    // Mode sequencer
    // Reset, run and isolation with entry at the reset pin release
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_RUN: begin
                if (chip_rst) begin
                    mode_d = MODE_RESET;
                end
            end
            MODE_RESET: begin
                if (!chip_rst) begin
                    mode_d = ctl.entry_req ? MODE_ISOLATE : MODE_RUN;
                end
            end
            MODE_ISOLATE: begin
                if (chip_rst) begin
                    mode_d = MODE_RESET;
                end
            end
        endcase
    end

    // Mode state and its registered status outputs
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_q        <= MODE_RESET;
            reset_state_o <= 1'b1;
            isolation_o   <= 1'b0;
        end else begin
            mode_q        <= mode_d;
            reset_state_o <= (mode_d == MODE_RESET);
            isolation_o   <= (mode_d == MODE_ISOLATE);
        end
    end

    // Pad state follows the current mode
    assign ctl.pads_reset = (mode_q == MODE_RESET);
    assign ctl.pads_iso   = (mode_q == MODE_ISOLATE);

    // ============================================================
    // Interrupts
    // Events: a reset source seen, isolation entered, isolation left
    always_comb begin
        irq_evt              = IRQ_RST;
        irq_evt[IRQ_CAUSE]   = chip_rst;
        irq_evt[IRQ_ISO_ON]  = (mode_d == MODE_ISOLATE) && (mode_q != MODE_ISOLATE);
        irq_evt[IRQ_ISO_OFF] = (mode_d != MODE_ISOLATE) && (mode_q == MODE_ISOLATE);
        irq_stat_d           = irq_stat_q;
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~wdata_i[IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_evt;                       // Set wins over clear
    end

    // Sticky status, mask and the level interrupt output
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_stat_q <= IRQ_RST;
            irq_mask_q <= IRQ_RST;
            irq_o      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask) begin
                irq_mask_q <= wdata_i[IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_d & (wr_mask ? wdata_i[IRQ_W-1:0] : irq_mask_q));
        end
    end

    // ============================================================
    // Register read port
    // Data stand one cycle after the read strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_o <= BYTE_ZERO;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_CAUSE: begin
                    rdata_o <= {{(DATA_W-CAUSE_W){1'b0}}, cause_q};
                end
                ADDR_IRQ_STAT: begin
                    rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
                end
                ADDR_IRQ_MASK: begin
                    rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
                end
                ADDR_MODE: begin
                    rdata_o             <= BYTE_ZERO;
                    rdata_o[MODE_B_ISO] <= (mode_q == MODE_ISOLATE);
                    rdata_o[MODE_B_RST] <= (mode_q == MODE_RESET);
                end
                default: begin
                    rdata_o <= BYTE_ZERO;
                end
            endcase
        end else begin
            rdata_o <= BYTE_ZERO;
        end
    end

    // ============================================================
    // Submodules
    // Isolation entry detector on the shared pin
    rci_iso_detect u_det (
        .mclk_i        (mclk_i),
        .sys_rst_i     (sys_rst_i),
        .ext_reset_n_i (ext_reset_n_i),
        .mode_pin_i    (mode_pin),
        .ctl           (ctl)
    );

    // Pad drive and pull control
    rci_pad_ctrl #(
        .PINS        (PINS),
        .ISO_PULL_UP (ISO_PULL_UP)
    ) u_pad (
        .mclk_i        (mclk_i),
        .sys_rst_i     (sys_rst_i),
        .gpio_out_i    (gpio_out_i),
        .gpio_oe_i     (gpio_oe_i),
        .ctl           (ctl),
        .pin_out_o     (pin_out_o),
        .pin_oe_o      (pin_oe_o),
        .pin_pull_en_o (pin_pull_en_o),
        .pin_pull_up_o (pin_pull_up_o)
    );

    // ============================================================
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Reset pin low then released, with the mode pin high across the release
    sequence s_held_across;
        (mode_q == MODE_RESET) && !ext_reset_n_i && mode_pin
        ##1 ext_reset_n_i && mode_pin && !clock_fail_i && !watchdog_i
            && !sw_reset_i && !bad_mode_key_i;
    endsequence

    // A read of the cause byte in a quiet cycle
    sequence s_quiet_read;
        rd_cause && !chip_rst ##1 !chip_rst;
    endsequence

    chk_pin_flag_set: assert property (!ext_reset_n_i |=> cause_q[CAUSE_EXT])
        else $error("Pin reset flag not set");

    chk_multi_source: assert property (
        (watchdog_i && sw_reset_i) |=> (cause_q[CAUSE_WDT] && cause_q[CAUSE_SW]))
        else $error("Simultaneous sources not all flagged");

    chk_read_clears: assert property (
        s_quiet_read |-> (cause_q == CAUSE_RST)
            && (rdata_o[CAUSE_W-1:0] == $past(cause_q)))
        else $error("Cause read did not return then clear");

    chk_clock_fail_bit: assert property (
        clock_fail_i |=> (cause_q[CAUSE_CFD] && (rdata_o[DATA_W-1:CAUSE_W] == '0)))
        else $error("Clock failure flag not set");

    chk_key_flag_bit: assert property (
        (bad_mode_key_i && ext_reset_n_i && !watchdog_i) |=> cause_q[CAUSE_SW])
        else $error("Bad key did not set software flag");

    chk_iso_entry: assert property (
        s_held_across |=> (mode_q == MODE_ISOLATE) && isolation_o)
        else $error("Isolation not entered at reset release");

    // Any active source puts the controller into reset at the next edge
    chk_src_to_reset: assert property (
        chip_rst |=> (mode_q == MODE_RESET) && reset_state_o && !isolation_o)
        else $error("Active reset source did not enter reset");

    chk_iso_pads: assert property (
        (mode_q == MODE_ISOLATE) |=> (pin_oe_o == '0) && (pin_pull_en_o == '1))
        else $error("Pads not released in isolation");

    chk_iso_exit: assert property (
        (mode_q == MODE_ISOLATE && !ext_reset_n_i) |=> (mode_q == MODE_RESET) && reset_state_o)
        else $error("Isolation not left on reset pin low");

    chk_reset_weak_low: assert property (
        (mode_q == MODE_RESET)
            |=> (pin_pull_en_o == '1) && (pin_pull_up_o == '0) && (pin_oe_o == '0))
        else $error("Pads not weak low during reset");

    chk_irq_level: assert property (
        (irq_stat_q[IRQ_CAUSE] && irq_mask_q[IRQ_CAUSE] && !wr_i) |=> irq_o)
        else $error("Unmasked status did not raise interrupt");

endmodule : rci_reset_seq
`default_nettype wire

// File: dv/rci_tester_model.sv
// Board tester model that drives the external reset pin and the pad inputs
`timescale 1ns/1ps
`default_nettype none
module rci_tester_model
    import rci_pkg::*;
(
    input  wire logic                 mclk_i,
    output var  logic                 ext_reset_n_o,
    output var  logic [GPIO_PINS-1:0] gpio_in_o
);
    // ============================================================
    // Pad levels
    logic                 mode_pin_q;
    logic [GPIO_PINS-1:0] bg_q;

    // Start with reset high and the shared pin low
    initial begin
        ext_reset_n_o = 1'b1;
        mode_pin_q    = 1'b0;              // Low unless entry is wanted
        bg_q          = 41'h0a5_5a5a_a5a5;
    end

    // Other pads toggle so that a stale level never passes for a drive
    always @(posedge mclk_i) begin
        bg_q <= ~bg_q;
    end

    // Mode entry rides on the shared port pin
    always_comb begin
        gpio_in_o                 = bg_q;
        gpio_in_o[SHARED_PIN_IDX] = mode_pin_q;
    end

    // Drive the reset pin; called just after a rising edge
    task automatic drive_ext(input logic low);
        ext_reset_n_o <= ~low;
    endtask : drive_ext

    // Hold reset low, then release it with the mode pin high across the rise
    task automatic enter_iso(input int unsigned low_cycles);
        mode_pin_q    <= 1'b1;
        ext_reset_n_o <= 1'b0;
        repeat (low_cycles) @(posedge mclk_i);
        ext_reset_n_o <= 1'b1;             // Reset then stays high
        repeat (2) @(posedge mclk_i);
        mode_pin_q    <= 1'b0;
    endtask : enter_iso
endmodule : rci_tester_model
`default_nettype wire

// File: dv/reset_cause_and_isolation_entry_bench.sv
// Self-checking bench for the reset cause log and isolation sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_isolation_entry_bench;
    import rci_pkg::*;

    // ============================================================
    // Signals
    localparam logic [GPIO_PINS-1:0] ISO_UP = 41'h155_5555_5555;
    localparam logic [GPIO_PINS-1:0] ALL1   = {GPIO_PINS{1'b1}};

    typedef struct packed {
        logic [4:0]        src;    // clock fail, watchdog, sw, bad key, pin
        logic [DATA_W-1:0] cause;
    } rci_row_t;

    logic                 mclk_i;
    logic                 sys_rst_i;
    logic                 ext_reset_n;
    logic                 clock_fail_i;
    logic                 watchdog_i;
    logic                 sw_reset_i;
    logic                 bad_mode_key_i;
    logic [GPIO_PINS-1:0] gpio_in;
    logic [GPIO_PINS-1:0] gpio_out_i;
    logic [GPIO_PINS-1:0] gpio_oe_i;
    logic [ADDR_W-1:0]    addr_i;
    logic [DATA_W-1:0]    wdata_i;
    logic                 wr_i;
    logic                 rd_i;
    logic [DATA_W-1:0]    rdata_o;
    logic                 irq_o;
    logic                 reset_state_o;
    logic                 isolation_o;
    logic [GPIO_PINS-1:0] pin_out_o;
    logic [GPIO_PINS-1:0] pin_oe_o;
    logic [GPIO_PINS-1:0] pin_pull_en_o;
    logic [GPIO_PINS-1:0] pin_pull_up_o;
    logic [DATA_W-1:0]    v;
    int                   failures;
    int                   checks_done;

    rci_row_t rows [7] = '{'{5'h10, 8'h08}, '{5'h08, 8'h04}, '{5'h04, 8'h02},
                           '{5'h02, 8'h02}, '{5'h01, 8'h01}, '{5'h19, 8'h0d},
                           '{5'h1f, 8'h0f}};

    // ============================================================
    // Design and far side
    rci_reset_seq #(.ISO_PULL_UP(ISO_UP)) i_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ext_reset_n_i(ext_reset_n),
        .clock_fail_i(clock_fail_i), .watchdog_i(watchdog_i), .sw_reset_i(sw_reset_i),
        .bad_mode_key_i(bad_mode_key_i), .gpio_in_i(gpio_in), .gpio_out_i(gpio_out_i),
        .gpio_oe_i(gpio_oe_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .reset_state_o(reset_state_o),
        .isolation_o(isolation_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pin_pull_en_o(pin_pull_en_o), .pin_pull_up_o(pin_pull_up_o)
    );

    rci_tester_model i_tester (
        .mclk_i(mclk_i), .ext_reset_n_o(ext_reset_n), .gpio_in_o(gpio_in)
    );

    // ============================================================
    // Clock and hang guard
    initial mclk_i = 1'b0;
    always #5 mclk_i = ~mclk_i;

    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        conclude();
    end

    // ============================================================
    // Tasks
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic chk_pads(input logic [GPIO_PINS-1:0] up);
        check("pin_oe", pin_oe_o, '0);
        check("pin_out", pin_out_o, '0);
        check("pin_pull_en", pin_pull_en_o, ALL1);
        check("pin_pull_up", pin_pull_up_o, up);
    endtask : chk_pads

    // One cycle of reset sources, then the weak low pad state one edge later
    task automatic pulse_src(input logic [4:0] s);
        @(posedge mclk_i);
        {clock_fail_i, watchdog_i, sw_reset_i, bad_mode_key_i} <= s[4:1];
        i_tester.drive_ext(s[0]);
        @(posedge mclk_i);
        {clock_fail_i, watchdog_i, sw_reset_i, bad_mode_key_i} <= 4'h0;
        i_tester.drive_ext(1'b0);
        #1;
        check("reset_state_on", reset_state_o, 1'b1);
        @(posedge mclk_i);
        #1;
        check("reset_state_off", reset_state_o, 1'b0);
        chk_pads('0);
    endtask : pulse_src

    // ============================================================
    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        {clock_fail_i, watchdog_i, sw_reset_i, bad_mode_key_i} = 4'h0;
        gpio_out_i = 41'h0f0_f0f0_f0f0;
        gpio_oe_i  = 41'h1ff_0000_ffff;
        addr_i     = '0;
        wdata_i    = '0;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        repeat (9) @(posedge mclk_i);
        #1;
        check("reset_state_por", reset_state_o, 1'b1);
        chk_pads('0);
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        // Run mode passes the core drive to the pads
        check("pin_oe_run", pin_oe_o, gpio_oe_i);
        check("pin_out_run", pin_out_o, gpio_out_i);
        reg_rd(ADDR_CAUSE, v);
        check("cause_por", v, BYTE_ZERO);

        // Each row: sources, cause byte, then cleared by the read
        foreach (rows[i]) begin
            pulse_src(rows[i].src);
            reg_rd(ADDR_CAUSE, v);
            check("cause_row", v, rows[i].cause);
            reg_rd(ADDR_CAUSE, v);
            check("cause_cleared", v, BYTE_ZERO);
        end

        // Ignored writes and an unmapped address
        reg_wr(ADDR_CAUSE, 8'h0f);  // Reserved bits written as zeros
        reg_rd(ADDR_CAUSE, v);
        check("cause_wr_ignored", v, BYTE_ZERO);
        reg_wr(ADDR_MODE, 8'h03);
        reg_rd(ADDR_MODE, v);
        check("mode_run", v, 8'h00);
        reg_rd(16'h1f96, v);
        check("unmapped", v, 8'h00);

        // Interrupt: masked, unmasked, cleared
        reg_wr(ADDR_IRQ_STAT, 8'h07);
        reg_wr(ADDR_IRQ_MASK, 8'h00);
        pulse_src(5'h08);
        check("irq_masked", irq_o, 1'b0);
        reg_rd(ADDR_IRQ_STAT, v);
        check("irq_stat", v, 8'h01);
        reg_wr(ADDR_IRQ_MASK, 8'h01);
        #1;
        check("irq_on", irq_o, 1'b1);
        reg_rd(ADDR_IRQ_MASK, v);
        check("irq_mask", v, 8'h01);
        reg_wr(ADDR_IRQ_STAT, 8'h01);
        #1;
        check("irq_cleared", irq_o, 1'b0);
        reg_rd(ADDR_CAUSE, v);
        check("cause_wdt", v, 8'h04);

        // Isolation entry at the reset pin rise, exit by reset low
        reg_wr(ADDR_IRQ_MASK, 8'h06);
        @(posedge mclk_i);
        i_tester.enter_iso(3);
        #1;
        check("iso_entered", isolation_o, 1'b1);
        check("iso_not_reset", reset_state_o, 1'b0);
        chk_pads(ISO_UP);
        check("irq_iso", irq_o, 1'b1);
        reg_rd(ADDR_MODE, v);
        check("mode_iso", v, 8'h01);
        reg_rd(ADDR_IRQ_STAT, v);
        check("stat_iso", v, 8'h03);
        @(posedge mclk_i);
        i_tester.drive_ext(1'b1);
        @(posedge mclk_i);
        i_tester.drive_ext(1'b0);
        #1;
        check("iso_left", isolation_o, 1'b0);
        check("iso_to_reset", reset_state_o, 1'b1);
        @(posedge mclk_i);
        #1;
        chk_pads('0);
        reg_rd(ADDR_IRQ_STAT, v);
        check("stat_exit", v, 8'h07);
        reg_rd(ADDR_CAUSE, v);
        check("cause_pin", v, 8'h01);

        // Mode register while the pin holds reset, then read data fall back to zero
        @(posedge mclk_i);
        i_tester.drive_ext(1'b1);
        reg_rd(ADDR_MODE, v);
        check("mode_reset", v, 8'h02);
        @(posedge mclk_i);
        i_tester.drive_ext(1'b0);
        #1;
        check("rdata_idle", rdata_o, 8'h00);
        conclude();
    end
endmodule : reset_cause_and_isolation_entry_bench
`default_nettype wire
